//--- fwsr_ctrl.sv
// host-side controller that writes and polls the flash status byte
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fwsr_defs.svh"
module fwsr_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [18:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    import fwsr_pkg::*;
    typedef struct packed {
        fwsr_state_t st;
        fwsr_op_t op;
        logic [18:0] addr;
        logic [7:0] data;
        logic [7:0] wdat;
        logic [7:0] first;
        logic [7:0] last;
        logic [7:0] rbyte;
        logic [1:0] nrd;
        logic recheck;
        logic busy;
        logic done;
        logic fail;
        logic timer;
        logic reject;
        logic stale;
        logic awt;
        logic wt;
        logic [3:0] awa;
        logic [31:0] wd;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic cyc_start;
        logic cyc_wr;
        logic awrdy;
        logic wrdy;
        logic arrdy;
    } fwsr_ctl_t;
    fwsr_ctl_t s, next_s;
    fwsr_pins_t pins;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    logic toggled;
    logic [3:0] ridx;

    fwsr_bus_cycle u_cycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(s.cyc_start),
        .is_write(s.cyc_wr),
        .addr(s.addr),
        .wdata(s.wdat),
        .pin_din(flash_dq_in),
        .pins(pins),
        .done(cyc_done),
        .rdata(cyc_rdata)
    );

    // toggle bit one for program polls, bit two as well for erase polls
    assign toggled = (s.first[`FWSR_BIT_TOG1] != s.last[`FWSR_BIT_TOG1]) ||
        (s.op == FWSR_OP_ERS && s.first[`FWSR_BIT_TOG2] != s.last[`FWSR_BIT_TOG2]);
    assign ridx = s_axi_araddr[5:2];

    always_comb
    begin
        next_s = s;
        next_s.cyc_start = 1'b0;
        // write channel: address and data in either order
        if (s_axi_awvalid && s.awrdy)
        begin
            next_s.awt = 1'b1;
            next_s.awa = s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid && s.wrdy)
        begin
            next_s.wt = 1'b1;
            next_s.wd = s_axi_wdata;
        end
        if (s.awt && s.wt && !s.bvalid)
        begin
            next_s.awt = 1'b0;
            next_s.wt = 1'b0;
            next_s.bvalid = 1'b1;
            case (s.awa)
                `FWSR_REG_ADDR: next_s.addr = s.wd[18:0];
                `FWSR_REG_DATA: next_s.data = s.wd[7:0];
                `FWSR_REG_CTRL:
                    if (!s.busy)
                    begin
                        next_s.busy = 1'b1;
                        next_s.done = 1'b0;
                        next_s.fail = 1'b0;
                        next_s.reject = 1'b0;
                        next_s.stale = 1'b0;
                        next_s.nrd = 2'h0;
                        next_s.recheck = 1'b0;
                        next_s.st = FWSR_CYC;
                        next_s.cyc_start = 1'b1;
                        next_s.cyc_wr = 1'b0;
                        next_s.wdat = s.data;
                        if (s.wd[`FWSR_CTRL_POLL_PGM])
                            next_s.op = FWSR_OP_PGM;
                        else if (s.wd[`FWSR_CTRL_POLL_ERS])
                            next_s.op = FWSR_OP_ERS;
                        else if (s.wd[`FWSR_CTRL_WRITE])
                        begin
                            next_s.op = FWSR_OP_WIN;
                            next_s.st = FWSR_WIN_PRE;
                        end
                        else if (s.wd[`FWSR_CTRL_RESET])
                        begin
                            next_s.op = FWSR_OP_RST;
                            next_s.wdat = `FWSR_RST_CMD;
                            next_s.cyc_wr = 1'b1;
                        end
                        else if (s.wd[`FWSR_CTRL_READ])
                            next_s.op = FWSR_OP_RD;
                        else
                        begin
                            next_s.busy = 1'b0;
                            next_s.st = FWSR_IDLE;
                            next_s.cyc_start = 1'b0;
                        end
                    end
                default: ;
            endcase
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s_axi_arvalid && s.arrdy)
        begin
            next_s.rvalid = 1'b1;
            case (ridx)
                `FWSR_REG_ADDR: next_s.rdata = {13'h0000, s.addr};
                `FWSR_REG_DATA: next_s.rdata = {24'h000000, s.data};
                `FWSR_REG_STAT: next_s.rdata = {26'h0000000, s.stale, s.reject, s.timer,
                    s.fail, s.done, s.busy};
                `FWSR_REG_RDATA: next_s.rdata = {24'h000000, s.rbyte};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        // ready flags registered so every bus output except the tied-off bresp and rresp leaves a flop
        next_s.awrdy = !next_s.awt;
        next_s.wrdy = !next_s.wt;
        next_s.arrdy = !next_s.rvalid;

        case (s.st)
            FWSR_IDLE: ;
            FWSR_WIN_PRE:
                if (cyc_done || !s.cyc_wr)
                begin
                    // read timer bit, write the sector erase command, read it again
                    next_s.cyc_start = 1'b1;
                    next_s.cyc_wr = 1'b0;
                    next_s.st = FWSR_CYC;
                end
            FWSR_CYC:
                if (cyc_done)
                begin
                    if (s.op == FWSR_OP_RST)
                    begin
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.st = FWSR_IDLE;
                    end
                    else if (s.op == FWSR_OP_WIN)
                    begin
                        next_s.timer = cyc_rdata[`FWSR_BIT_WTMR];
                        if (!s.cyc_wr && s.nrd == 2'h0)
                        begin
                            next_s.first = cyc_rdata;
                            next_s.nrd = 2'h1;
                            next_s.cyc_wr = 1'b1;
                            next_s.cyc_start = 1'b1;
                        end
                        else if (s.cyc_wr)
                        begin
                            next_s.cyc_wr = 1'b0;
                            next_s.cyc_start = 1'b1;
                        end
                        else
                        begin
                            // high after the command: may have been ignored
                            next_s.reject = cyc_rdata[`FWSR_BIT_WTMR];
                            next_s.busy = 1'b0;
                            next_s.done = 1'b1;
                            next_s.st = FWSR_IDLE;
                        end
                    end
                    else
                    begin
                        next_s.rbyte = cyc_rdata;
                        next_s.first = s.last;
                        next_s.last = cyc_rdata;
                        next_s.timer = cyc_rdata[`FWSR_BIT_WTMR];
                        if (s.nrd != 2'h2)
                            next_s.nrd = s.nrd + 2'h1;
                        next_s.st = FWSR_EVAL;
                    end
                end
            FWSR_EVAL:
            begin
                next_s.st = FWSR_CYC;
                next_s.cyc_start = 1'b1;
                if (s.op == FWSR_OP_RD)
                begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                    next_s.st = FWSR_IDLE;
                    next_s.cyc_start = 1'b0;
                end
                else if (s.nrd == 2'h2)
                begin
                    if (!toggled)
                    begin
                        // status was read, array data follows on a fresh read
                        next_s.op = FWSR_OP_RD;
                        next_s.stale = 1'b1;
                    end
                    else if (s.recheck)
                    begin
                        next_s.fail = 1'b1;
                        next_s.busy = 1'b0;
                        next_s.st = FWSR_IDLE;
                        next_s.cyc_start = 1'b0;
                    end
                    else if (s.last[`FWSR_BIT_TOUT])
                        next_s.recheck = 1'b1;
                end
            end
            default: next_s.st = FWSR_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign s_axi_awready = s.awrdy;
    assign s_axi_wready = s.wrdy;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = 2'b00;
    assign s_axi_arready = s.arrdy;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = 2'b00;
    assign flash_addr = pins.addr;
    assign flash_dq_out = pins.dout;
    assign flash_dq_oe = pins.dout_oe;
    assign flash_ce_n = pins.ce_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_we_n = pins.we_n;

    sequence fwsr_two_reads_s;
        s.st == FWSR_EVAL && s.op != FWSR_OP_RD && s.nrd == 2'h2 && !toggled;
    endsequence
    double_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fwsr_two_reads_s |=> s.op == FWSR_OP_RD && s.cyc_start)
        else $error("double read with equal toggles did not go to data read");
    fail_recheck_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.st == FWSR_EVAL && s.op != FWSR_OP_RD && s.nrd == 2'h2 && toggled && s.recheck
        |=> s.fail && !s.busy)
        else $error("persistent toggle after time-out not flagged");
    reset_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.op == FWSR_OP_RST && s.cyc_start |=> pins.dout == `FWSR_RST_CMD && pins.dout_oe)
        else $error("reset command byte not driven");
    poll_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pins.ce_n |-> pins.addr == s.addr)
        else $error("poll address changed during cycle");
    restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.st == FWSR_IDLE ##1 s.st == FWSR_CYC |-> s.nrd == 2'h0)
        else $error("poll did not restart from first read");
    win_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.op == FWSR_OP_WIN && $fell(s.busy) |-> s.reject == s.timer)
        else $error("reject not taken from second timer read");
    stale_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.stale) |-> s.st == FWSR_CYC ##[1:30] cyc_done)
        else $error("no fresh read after polling finished");
    oe_we_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(!pins.oe_n && !pins.we_n))
        else $error("read and write strobes together");
endmodule

//--- fwsr_defs.svh
// constants for the flash status-polling controller
`ifndef FWSR_DEFS_SVH
`define FWSR_DEFS_SVH
`define FWSR_REG_CTRL 4'h0
`define FWSR_REG_ADDR 4'h1
`define FWSR_REG_DATA 4'h2
`define FWSR_REG_STAT 4'h3
`define FWSR_REG_RDATA 4'h4
`define FWSR_REG_WIN 4'h5
`define FWSR_CTRL_POLL_PGM 0
`define FWSR_CTRL_POLL_ERS 1
`define FWSR_CTRL_WRITE 2
`define FWSR_CTRL_READ 3
`define FWSR_CTRL_RESET 4
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_TIMER 3
`define FWSR_ST_REJECT 4
`define FWSR_ST_STALE 5
`define FWSR_BIT_POLL 7
`define FWSR_BIT_TOG1 6
`define FWSR_BIT_TOUT 5
`define FWSR_BIT_WTMR 3
`define FWSR_BIT_TOG2 2
`define FWSR_CYC_NS 5
`define FWSR_RD_NS 90
`define FWSR_RD_CYC ((`FWSR_RD_NS + `FWSR_CYC_NS - 1) / `FWSR_CYC_NS)
`define FWSR_WR_NS 45
`define FWSR_WR_CYC ((`FWSR_WR_NS + `FWSR_CYC_NS - 1) / `FWSR_CYC_NS)
`define FWSR_RST_CMD 8'hF0
`define FWSR_ADDR_W 19
`endif

//--- fwsr_pkg.sv
// types for the flash status-polling controller
package fwsr_pkg;
    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] dout;
        logic dout_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fwsr_pins_t;
    typedef enum logic [3:0] {
        FWSR_IDLE, FWSR_CYC, FWSR_GAP, FWSR_EVAL, FWSR_WIN_PRE, FWSR_WIN_POST
    } fwsr_state_t;
    typedef enum logic [2:0] {
        FWSR_OP_PGM, FWSR_OP_ERS, FWSR_OP_WR, FWSR_OP_RD, FWSR_OP_RST, FWSR_OP_WIN
    } fwsr_op_t;
endpackage

//--- fwsr_bus_cycle.sv
// one strobed read or write cycle on the flash parallel pins
`timescale 1ns/1ps
`include "fwsr_defs.svh"
module fwsr_bus_cycle (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic is_write,
    input wire logic [18:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pin_din,
    output fwsr_pkg::fwsr_pins_t pins,
    output logic done,
    output logic [7:0] rdata
);
    import fwsr_pkg::*;
    typedef struct packed {
        fwsr_pins_t pins;
        logic [5:0] cnt;
        logic busy;
        logic wr;
        logic done;
        logic [7:0] rdata;
    } fwsr_cyc_t;
    fwsr_cyc_t s, next_s;
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (!s.busy && start)
        begin
            next_s.busy = 1'b1;
            next_s.wr = is_write;
            next_s.cnt = is_write ? 6'(`FWSR_WR_CYC) : 6'(`FWSR_RD_CYC);
            next_s.pins.addr = addr;
            next_s.pins.dout = wdata;
            next_s.pins.dout_oe = is_write;
            next_s.pins.ce_n = 1'b0;
            next_s.pins.oe_n = is_write;
            next_s.pins.we_n = !is_write;
        end
        else if (s.busy)
        begin
            if (s.cnt > 6'h01)
                next_s.cnt = s.cnt - 6'h01;
            else
            begin
                // every read is a full strobe so the device counts it
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                if (!s.wr)
                    next_s.rdata = pin_din;
                next_s.pins.ce_n = 1'b1;
                next_s.pins.oe_n = 1'b1;
                next_s.pins.we_n = 1'b1;
                next_s.pins.dout_oe = 1'b0;
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.pins.ce_n <= 1'b1;
            s.pins.oe_n <= 1'b1;
            s.pins.we_n <= 1'b1;
        end
        else
            s <= next_s;
    end
    assign pins = s.pins;
    assign done = s.done;
    assign rdata = s.rdata;
endmodule

//--- fwsr_flash_model.sv
// behavioural flash device answering status reads and command writes
`timescale 1ns/1ps
module fwsr_flash_model #(
    parameter logic [7:0] INIT = 8'hA5
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    input wire logic [7:0] dq_wr,
    input wire logic dq_oe,
    output logic [7:0] dq_rd,
    input wire logic load,
    input wire logic [1:0] op_kind,
    input wire logic op_tout,
    input wire logic op_win,
    input wire logic op_prot,
    input wire logic [7:0] op_reads,
    input wire logic [18:0] op_addr,
    input wire logic [7:0] op_data,
    output logic busy,
    output logic [7:0] acc_cnt,
    output logic addr_bad
);
    logic [1:0] op = 2'd0;
    logic tout, win, prot, insec;
    logic tg = 1'b0;
    int left;
    logic [7:0] arr = INIT;
    logic [7:0] cur = 8'h00;
    logic [7:0] dat, wr_d;
    logic [18:0] oa;
    wire rd_sel = ~ce_n & ~oe_n;
    wire wr_sel = ~ce_n & ~we_n & oe_n;
    initial acc_cnt = 8'h00;
    initial addr_bad = 1'b0;
    assign busy = (op != 2'd0);
    // released bus shows the inverse so a late sample cannot match by luck
    assign dq_rd = rd_sel ? cur : ~cur;
    // status is live from the load on, standing in for the final strobe
    always @(posedge load)
    begin
        op = op_kind;
        tout = op_tout;
        win = op_win;
        prot = op_prot;
        left = op_reads;
        dat = op_data;
        oa = op_addr;
        addr_bad = 1'b0;
    end
    always @(posedge rd_sel)
    begin
        // a timed-out operation never finishes by itself
        if (op != 2'd0 && left == 0 && !tout)
        begin
            if (!prot)
                arr = (op == 2'd2) ? 8'hFF : dat;
            op = 2'd0;
        end
        if (left > 0)
            left = left - 1;
        tg = ~tg;
        insec = (addr[18:16] == oa[18:16]);
        case (op)
            // kind 3: program issued while an erase is suspended
            2'd1, 2'd3:
            begin
                addr_bad = addr_bad | (addr != oa);
                cur = {~dat[7], tg, tout, dat[4:0]};
            end
            2'd2:
            begin
                addr_bad = addr_bad | ~insec;
                cur = {1'b0, tg, tout, 1'b1, ~win, insec & tg, 2'b11};
            end
            default: cur = arr;
        endcase
    end
    always @*
    begin
        if (wr_sel && dq_oe)
            wr_d = dq_wr;
    end
    always @(negedge wr_sel)
    begin
        if (wr_d == 8'hF0)
            op = 2'd0;
        else if (op == 2'd2 && win)
            acc_cnt = acc_cnt + 8'h01;
    end
endmodule

//--- flash_write_status_reporting_tb.sv
// self-checking bench for the flash status-polling controller
`timescale 1ns/1ps
`include "fwsr_defs.svh"
module flash_write_status_reporting_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, rv;
    logic [1:0] bresp, rresp, op_kind;
    logic [3:0] wstrb;
    logic [18:0] f_addr, op_addr;
    logic [7:0] dq_out, dq_in, op_data, op_reads, acc_cnt, arr_exp, c0;
    logic dq_oe, ce_n, oe_n, we_n, load, op_tout, op_win, op_prot, mbusy, addr_bad;
    int fail_count, num_checks;
    fwsr_ctrl u_fwsr_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flash_addr(f_addr), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n));
    fwsr_flash_model #(.INIT(8'hA5)) u_fwsr_flash_model (.ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(f_addr), .dq_wr(dq_out), .dq_oe(dq_oe), .dq_rd(dq_in),
        .load(load), .op_kind(op_kind), .op_tout(op_tout), .op_win(op_win),
        .op_prot(op_prot), .op_reads(op_reads), .op_addr(op_addr), .op_data(op_data),
        .busy(mbusy), .acc_cnt(acc_cnt), .addr_bad(addr_bad));
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task hung;
        fail_count++;
        end_sim;
    endtask
    function logic [31:0] ra(input logic [3:0] r);
        return {26'h0, r, 2'b00};
    endfunction
    task axi_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        chk_word({30'h0, bresp}, 32'h0);
        bready <= 1'b0;
        if (n == 100)
            hung;
    endtask
    task axi_rd(input logic [31:0] a, output logic [31:0] d);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        chk_word({30'h0, rresp}, 32'h0);
        rready <= 1'b0;
        if (n == 100)
            hung;
    endtask
    task ctrl(input int b);
        int n;
        axi_wr(ra(`FWSR_REG_CTRL), 32'h1 << b);
        for (n = 0; n < 300; n++)
        begin
            axi_rd(ra(`FWSR_REG_STAT), rv);
            if (rv[`FWSR_ST_BUSY] === 1'b0)
                break;
        end
        if (n == 300)
            hung;
    endtask
    // puts the device model into a running operation as if just commanded
    task arm(input logic [1:0] k, input logic t, input logic w, input logic p,
        input logic [7:0] r, input logic [18:0] a, input logic [7:0] d);
        @(posedge aclk);
        op_kind <= k;
        op_tout <= t;
        op_win <= w;
        op_prot <= p;
        op_reads <= r;
        op_addr <= a;
        op_data <= d;
        load <= 1'b1;
        @(posedge aclk);
        load <= 1'b0;
        axi_wr(ra(`FWSR_REG_ADDR), {13'h0, a});
        axi_wr(ra(`FWSR_REG_DATA), {24'h0, d});
    endtask
    task sc_reset;
        chk_bit(ce_n, 1'b1);
        chk_bit(dq_oe, 1'b0);
        axi_rd(ra(`FWSR_REG_STAT), rv);
        chk_bit(rv[`FWSR_ST_BUSY], 1'b0);
        axi_rd(32'h0000_0040, rv);
        chk_word(rv, 32'h0);
    endtask
    task sc_program(input logic [1:0] k, input logic [18:0] a, input logic [7:0] d,
        input logic p, input logic [7:0] r);
        arm(k, 1'b0, 1'b0, p, r, a, d);
        ctrl(`FWSR_CTRL_POLL_PGM);
        if (!p)
            arr_exp = d;
        chk_bit(rv[`FWSR_ST_DONE], 1'b1);
        chk_bit(rv[`FWSR_ST_FAIL], 1'b0);
        chk_bit(rv[`FWSR_ST_STALE], 1'b1);
        axi_rd(ra(`FWSR_REG_RDATA), rv);
        chk_word(rv, {24'h0, arr_exp});
        chk_bit(addr_bad, 1'b0);
        chk_bit(mbusy, 1'b0);
    endtask
    task sc_erase;
        arm(2'd2, 1'b0, 1'b0, 1'b0, 8'h04, 19'h3ABCD, 8'h00);
        ctrl(`FWSR_CTRL_POLL_ERS);
        arr_exp = 8'hFF;
        chk_bit(rv[`FWSR_ST_DONE], 1'b1);
        axi_rd(ra(`FWSR_REG_RDATA), rv);
        chk_word(rv, 32'h0000_00FF);
        chk_bit(addr_bad, 1'b0);
    endtask
    task sc_timeout;
        arm(2'd1, 1'b1, 1'b0, 1'b0, 8'h00, 19'h01234, 8'h5A);
        ctrl(`FWSR_CTRL_POLL_PGM);
        chk_bit(rv[`FWSR_ST_FAIL], 1'b1);
        chk_bit(rv[`FWSR_ST_DONE], 1'b0);
        chk_bit(rv[`FWSR_ST_STALE], 1'b0);
        ctrl(`FWSR_CTRL_RESET);
        chk_bit(mbusy, 1'b0);
        ctrl(`FWSR_CTRL_READ);
        axi_rd(ra(`FWSR_REG_RDATA), rv);
        chk_word(rv, {24'h0, arr_exp});
    endtask
    task sc_window(input logic w);
        arm(2'd2, 1'b0, w, 1'b0, 8'hC8, 19'h20000, 8'h30);
        c0 = acc_cnt;
        ctrl(`FWSR_CTRL_WRITE);
        chk_bit(rv[`FWSR_ST_TIMER], ~w);
        chk_bit(rv[`FWSR_ST_REJECT], ~w);
        chk_word({24'h0, acc_cnt}, {24'h0, c0 + {7'h0, w}});
        ctrl(`FWSR_CTRL_RESET);
        chk_bit(mbusy, 1'b0);
    endtask
    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, load} = 6'h00;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'hF;
        {op_kind, op_tout, op_win, op_prot} = 5'h00;
        {op_reads, op_data, op_addr} = {8'h00, 8'h00, 19'h0};
        fail_count = 0;
        num_checks = 0;
        arr_exp = 8'hA5;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        sc_reset;
        sc_program(2'd1, 19'h12345, 8'h3C, 1'b0, 8'h05);
        sc_program(2'd1, 19'h7FFFF, 8'hC3, 1'b0, 8'h01);
        sc_program(2'd1, 19'h00010, 8'h55, 1'b1, 8'h03);
        sc_program(2'd3, 19'h45678, 8'h81, 1'b0, 8'h02);
        sc_erase;
        sc_timeout;
        sc_window(1'b1);
        sc_window(1'b0);
        end_sim;
    end
endmodule
